/* lvd_consts.svh */
// constants of the low-voltage detector control block
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH
`define LVD_ADDR_CTRL 16'hFFBE
`define LVD_ADDR_LEVEL 16'hFFBF
`define LVD_ADDR_IRQ 16'hFFC0
`define LVD_CTRL_RST 8'h00
`define LVD_LEVEL_RST 3'h0
`define LVD_BIT_CMPEN 7
`define LVD_BIT_REFEN 4
`define LVD_BIT_ACT 1
`define LVD_BIT_FLAG 0
`define LVD_BIT_IRQREQ 0
`define LVD_BIT_IRQMSK 1
`define LVD_FULL_MASK 8'hFF
`define LVD_POC_HIGH_FIRST 3'h4
`define LVD_MV_0 13'h10CC
`define LVD_MV_1 13'h1004
`define LVD_MV_2 13'h0F3C
`define LVD_MV_3 13'h0E74
`define LVD_MV_4 13'h0DAC
`define LVD_MV_5 13'h0CE4
`define LVD_MV_6 13'h0C1C
`define LVD_MV_7 13'h0B22
`endif

/* lvd_control.sv */
// low-voltage detector control: registers, flag, interrupt and reset
`include "lvd_consts.svh"
module lvd_control
  import lvd_pkg::*;
#(
  parameter bit POC_PRESENT = 1'b0, // build option: power_on_clear fitted
  parameter bit POC_HIGH = 1'b0     // build option: high POWER_ON_CLEAR threshold
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic otherRstReq,
  input wire lvd_bus_t busIn,
  output logic [7:0] rdata,
  input wire logic cmpOutAsync,
  output logic cmpEnable,
  output logic refEnable,
  output logic [2:0] levelCode,
  output logic [12:0] thresholdMv,
  output logic undervoltageIrq,
  output logic irqToCpu,
  output logic lvdResetReq,
  output logic resetCauseSet
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // merge a masked write into an old value
  function automatic logic [7:0] mergeBits(input logic [7:0] old,
                                           input logic [7:0] val,
                                           input logic [7:0] msk);
    mergeBits = (old & ~msk) | (val & msk);
  endfunction

  // threshold in millivolts for a level code
  function automatic logic [12:0] levelMv(input logic [2:0] code);
    case (code)
      3'h0: levelMv = `LVD_MV_0;
      3'h1: levelMv = `LVD_MV_1;
      3'h2: levelMv = `LVD_MV_2;
      3'h3: levelMv = `LVD_MV_3;
      3'h4: levelMv = `LVD_MV_4;
      3'h5: levelMv = `LVD_MV_5;
      3'h6: levelMv = `LVD_MV_6;
      3'h7: levelMv = `LVD_MV_7;
      default: levelMv = `LVD_MV_0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  lvd_ctrl_t ctrl_q; // software control bits
  lvd_ctrl_t ctrl_d;
  logic [2:0] level_q; // level_code
  logic [2:0] level_d;
  logic irqMask_q; // undervoltage_irq_mask
  logic irqReq_q; // undervoltage_irq_request
  logic irqReq_d;
  logic sync1_q; // first synchroniser stage, read by sync2 only
  logic sync2_q;
  logic sync3_q;
  logic lowSeen_q; // filtered comparator: supply below threshold
  logic irq_q; // undervoltage_irq level
  logic rstReq_q; // internal reset request
  logic cause_q; // one-cycle reset cause pulse
  logic [7:0] rdata_q; // read data, valid the cycle after rd

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------

  wire ctrlHit = busIn.addr == `LVD_ADDR_CTRL;
  wire levelHit = busIn.addr == `LVD_ADDR_LEVEL;
  wire irqHit = busIn.addr == `LVD_ADDR_IRQ;
  wire ctrlWr = busIn.wr && ctrlHit;
  // partial writes to the level register are dropped
  wire levelWr = busIn.wr && levelHit &&
                 busIn.wmask == `LVD_FULL_MASK;
  wire irqWr = busIn.wr && irqHit;

  // control register as software sees it (flag appended below)
  wire [7:0] ctrlOld = {ctrl_q.cmpEn, 2'h0, ctrl_q.refEn, 2'h0,
                        ctrl_q.actSel, 1'b0};
  // bit or byte write, both honoured on the control register
  wire [7:0] ctrlNew = mergeBits(ctrlOld, busIn.wdata,
                                 busIn.wmask);

  // the high POWER_ON_CLEAR threshold makes codes 4..7 meaningless
  wire pocOverride = POC_HIGH &&
                     level_q >= `LVD_POC_HIGH_FIRST;

  // flag is forced low whenever the comparator is off
  wire flag = ctrl_q.cmpEn && lowSeen_q;
  // effects: no gating by stop mode, the detector keeps watch there
  wire effFlag = flag && !pocOverride;
  wire irqNext = effFlag && !ctrl_q.actSel;
  // only an actual undervoltage makes a reset, never the mode write
  wire rstNext = effFlag && ctrl_q.actSel;

  wire [7:0] ctrlRead = {ctrlOld[7:1], flag};
  wire [7:0] levelRead = {5'h00, level_q};
  wire [7:0] irqRead = {6'h00, irqMask_q, irqReq_q};
  wire [7:0] rdSel = ctrlHit ? ctrlRead :
                     levelHit ? levelRead :
                     irqHit ? irqRead : 8'h00;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------

  // control bits: a foreign reset clears, own reset leaves them alone
  always_comb begin
    ctrl_d = ctrl_q;
    if (otherRstReq) begin
      ctrl_d = '0;
    end else if (ctrlWr) begin
      ctrl_d.cmpEn = ctrlNew[`LVD_BIT_CMPEN];
      ctrl_d.refEn = ctrlNew[`LVD_BIT_REFEN];
      ctrl_d.actSel = ctrlNew[`LVD_BIT_ACT];
    end
  end

  // level code: full-byte writes only, high bits discarded
  always_comb begin
    level_d = level_q;
    if (otherRstReq) begin
      level_d = `LVD_LEVEL_RST;
    end else if (levelWr) begin
      level_d = busIn.wdata[2:0];
    end
  end

  // request flag: a new interrupt edge wins over a software clear
  always_comb begin
    irqReq_d = irqReq_q;
    if (irqWr && busIn.wmask[`LVD_BIT_IRQREQ]) begin
      irqReq_d = busIn.wdata[`LVD_BIT_IRQREQ];
    end
    if (irqNext && !irq_q) begin
      irqReq_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // software-visible registers, cleared by the reset pin
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= '0;
      level_q <= `LVD_LEVEL_RST;
      irqReq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      level_q <= level_d;
      irqReq_q <= irqReq_d;
    end
  end

  // the mask starts set so the detector cannot interrupt too early
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqMask_q <= 1'b1;
    end else if (irqWr && busIn.wmask[`LVD_BIT_IRQMSK]) begin
      irqMask_q <= busIn.wdata[`LVD_BIT_IRQMSK];
    end
  end

  // comparator is analog and asynchronous: three stages, change
  // accepted only when the last two agree, which also drops glitches
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      lowSeen_q <= 1'b0;
    end else begin
      sync1_q <= cmpOutAsync;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        lowSeen_q <= sync3_q;
      end
    end
  end

  // interrupt and reset request levels, and the cause pulse
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
      rstReq_q <= 1'b0;
      cause_q <= 1'b0;
    end else begin
      irq_q <= irqNext;
      rstReq_q <= rstNext;
      cause_q <= rstNext && !rstReq_q;
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (busIn.rd) begin
      rdata_q <= rdSel;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  assign rdata = rdata_q;
  assign cmpEnable = ctrl_q.cmpEn;
  // with POWER_ON_CLEAR fitted the reference never stops, so the bit is moot
  assign refEnable = POC_PRESENT ? 1'b1 : ctrl_q.refEn;
  assign levelCode = level_q;
  assign thresholdMv = levelMv(level_q);
  assign undervoltageIrq = irq_q;
  // nothing holds the irq back after enabling but the mask
  assign irqToCpu = irqReq_q && !irqMask_q;
  assign lvdResetReq = rstReq_q;
  assign resetCauseSet = cause_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ctrl_reserved_a: assert property (
    busIn.rd && ctrlHit |=> rdata[6:5] == 2'h0 && rdata[3:2] == 2'h0)
    else $error("reserved control bits read non-zero");

  cmp_enable_a: assert property (
    ctrlWr && !otherRstReq && busIn.wmask[`LVD_BIT_CMPEN]
    |=> cmpEnable == $past(busIn.wdata[`LVD_BIT_CMPEN]))
    else $error("comparator enable did not follow write");

  ref_forced_a: assert property (
    POC_PRESENT |-> refEnable)
    else $error("reference stopped with power-on-clear fitted");

  flag_off_a: assert property (
    busIn.rd && ctrlHit && !cmpEnable |=> rdata[0] == 1'b0)
    else $error("flag read high while comparator off");

  irq_mode_a: assert property (
    undervoltageIrq |-> $past(cmpEnable) && !$past(ctrl_q.actSel))
    else $error("irq raised outside interrupt mode");

  other_clear_a: assert property (
    otherRstReq |=> !cmpEnable && !ctrl_q.actSel)
    else $error("foreign reset left control bits set");

  own_keep_a: assert property (
    lvdResetReq && !otherRstReq && !busIn.wr |=> $stable(ctrl_q))
    else $error("own reset disturbed control bits");

  level_byte_a: assert property (
    busIn.wr && levelHit && busIn.wmask != `LVD_FULL_MASK &&
    !otherRstReq |=> $stable(levelCode))
    else $error("partial write changed level register");

  reset_cause_a: assert property (
    $rose(lvdResetReq) |-> resetCauseSet ##1 !resetCauseSet)
    else $error("reset cause pulse missing or too long");

  reset_only_low_a: assert property (
    lvdResetReq |-> $past(lowSeen_q) && $past(ctrl_q.actSel))
    else $error("reset raised without undervoltage");

  mask_start_a: assert property (
    $rose(rstn) |-> irqMask_q)
    else $error("irq mask not set after reset");

endmodule // lvd_control

/* lvd_control_bench.sv */
// self-checking bench for the low-voltage detector control block
`include "lvd_consts.svh"
module lvd_control_bench
  import lvd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and design instance
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 100 MHz system clock
  logic rstn = 1'b0; // reset pin, low active
  logic otherRstReq = 1'b0; // reset from any other source
  lvd_bus_t busIn = '0; // register port request
  logic cmpOutAsync = 1'b0; // comparator, 1 = supply low
  logic [7:0] rdata, rd8;
  logic cmpEnable, refEnable, undervoltageIrq, irqToCpu;
  logic lvdResetReq, resetCauseSet;
  logic [2:0] levelCode;
  logic [12:0] thresholdMv;
  int miscompares = 0; // mismatches seen
  int compares = 0; // comparisons made
  int cycles = 0; // timeout counter
  int pulses = 0; // cause pulses counted
  logic [7:0] v;
  logic pocRef, pocIrq, pocRst; // outputs of the power-on-clear copy
  // the hardware never times the software waits, so short stand-ins
  // for 2 ms and 0.2 ms keep the run well inside the timeout
  localparam int WAIT_REF = 200;
  localparam int WAIT_CMP = 20;
  lvd_control DUT (.clk(clk), .rstn(rstn), .otherRstReq(otherRstReq),
    .busIn(busIn), .rdata(rdata), .cmpOutAsync(cmpOutAsync),
    .cmpEnable(cmpEnable), .refEnable(refEnable), .levelCode(levelCode),
    .thresholdMv(thresholdMv), .undervoltageIrq(undervoltageIrq),
    .irqToCpu(irqToCpu), .lvdResetReq(lvdResetReq),
    .resetCauseSet(resetCauseSet));
  // second copy with power_on_clear fitted at its high threshold
  lvd_control #(.POC_PRESENT(1'b1), .POC_HIGH(1'b1)) dutPoc (.clk(clk),
    .rstn(rstn), .otherRstReq(otherRstReq), .busIn(busIn), .rdata(),
    .cmpOutAsync(cmpOutAsync), .cmpEnable(), .refEnable(pocRef),
    .levelCode(), .thresholdMv(), .undervoltageIrq(pocIrq), .irqToCpu(),
    .lvdResetReq(pocRst), .resetCauseSet());
  // clock, timeout and cause-pulse counting
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (resetCauseSet === 1'b1) pulses++;
    // the whole run needs about 430 cycles, so this is generous
    if (cycles > 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected threshold in mV for each level code
  function automatic logic [12:0] mv(input logic [2:0] c);
    case (c)
      3'h0: mv = 13'h10CC; // 4.3 V
      3'h1: mv = 13'h1004; // 4.1 V
      3'h2: mv = 13'h0F3C; // 3.9 V
      3'h3: mv = 13'h0E74; // 3.7 V
      3'h4: mv = 13'h0DAC; // 3.5 V
      3'h5: mv = 13'h0CE4; // 3.3 V
      3'h6: mv = 13'h0C1C; // 3.1 V
      default: mv = 13'h0B22; // 2.85 V
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one write cycle, strobe dropped at the next edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] m);
    @(posedge clk);
    busIn <= '{addr: a, wdata: d, wmask: m, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busIn.wr <= 1'b0;
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    busIn <= '{addr: a, wdata: 8'h00, wmask: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busIn.rd <= 1'b0;
    #1 rd8 = rdata;
  endtask
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(51));
    cyc(12);
    rstn <= 1'b1;
    // reset values of all three registers and the threshold output
    rd(`LVD_ADDR_CTRL); chk("ctrl rst", rd8, 8'h00);
    rd(`LVD_ADDR_LEVEL); chk("level rst", rd8, 8'h00);
    rd(`LVD_ADDR_IRQ); chk("mask rst", rd8, 8'h02);
    chk("thr rst", thresholdMv, 13'h10CC);
    $display("test reset done");
    // eight random level codes, each drawn afresh, partial writes refused
    for (int i = 0; i < 8; i++) begin
      v = 8'(($urandom % 8 + i) % 8);
      wr(`LVD_ADDR_LEVEL, v, 8'hFF);
      wr(`LVD_ADDR_LEVEL, ~v & 8'h07, 8'h07); // ignored lane write
      rd(`LVD_ADDR_LEVEL); chk("level rd", rd8, v);
      chk("levelCode", levelCode, v[2:0]);
      chk("thr", thresholdMv, mv(v[2:0]));
    end
    $display("test levels done");
    // random control bytes; flag and zero bits never written
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wr(`LVD_ADDR_CTRL, v, 8'hFF);
      rd(`LVD_ADDR_CTRL); chk("ctrl rd", rd8, v & 8'h92);
      chk("cmpEnable", cmpEnable, v[7]);
      chk("refEnable", refEnable, v[4]);
      chk("ref poc", pocRef, 1'b1);
    end
    // byte write sets comparator and reference, then a single-bit write drops reference only
    wr(`LVD_ADDR_CTRL, 8'h90, 8'hFF);
    wr(`LVD_ADDR_CTRL, 8'h00, 8'h10);
    #1 chk("bit clr ref", {cmpEnable, refEnable}, 2'b10);
    // unmapped place reads zero and takes no write
    wr(16'h1234, 8'hFF, 8'hFF);
    rd(16'h1234); chk("unmapped", rd8, 8'h00);
    rd(`LVD_ADDR_CTRL); chk("ctrl kept", rd8, 8'h80);
    $display("test control done");
    // interrupt mode: low supply reaches flag and irq, mask gates cpu
    wr(`LVD_ADDR_LEVEL, 8'h04, 8'hFF);
    wr(`LVD_ADDR_CTRL, 8'h90, 8'hFF);
    cmpOutAsync <= 1'b1;
    cyc(8);
    rd(`LVD_ADDR_CTRL); chk("flag set", rd8, 8'h91);
    chk("irq", undervoltageIrq, 1'b1);
    chk("irq poc", pocIrq, 1'b0);
    chk("irq masked", irqToCpu, 1'b0);
    wr(`LVD_ADDR_IRQ, 8'h01, 8'hFF); // unmask, request kept
    #1 chk("irq to cpu", irqToCpu, 1'b1);
    cmpOutAsync <= 1'b0;
    cyc(8);
    chk("irq gone", undervoltageIrq, 1'b0);
    wr(`LVD_ADDR_IRQ, 8'h00, 8'hFF); // clear request
    rd(`LVD_ADDR_IRQ); chk("req clr", rd8, 8'h00);
    // comparator off forces flag low
    cmpOutAsync <= 1'b1;
    wr(`LVD_ADDR_CTRL, 8'h10, 8'hFF);
    cyc(8);
    rd(`LVD_ADDR_CTRL); chk("flag off", rd8, 8'h10);
    chk("irq off", undervoltageIrq, 1'b0);
    $display("test interrupt done");
    // reset mode: software start sequence, no reset while supply fine
    cmpOutAsync <= 1'b0;
    cyc(8); // the filtered comparator must see a good supply first
    wr(`LVD_ADDR_IRQ, 8'h02, 8'hFF);
    wr(`LVD_ADDR_LEVEL, 8'h03, 8'hFF);
    wr(`LVD_ADDR_CTRL, 8'h10, 8'hFF);
    cyc(WAIT_REF);
    wr(`LVD_ADDR_CTRL, 8'h90, 8'hFF);
    cyc(WAIT_CMP);
    rd(`LVD_ADDR_CTRL); chk("flag clear", rd8, 8'h90);
    wr(`LVD_ADDR_CTRL, 8'h92, 8'hFF);
    cyc(8);
    chk("no reset", {lvdResetReq, pulses[0]}, 2'b00);
    cmpOutAsync <= 1'b1;
    cyc(8);
    chk("reset req", lvdResetReq, 1'b1);
    chk("rst poc", pocRst, 1'b1);
    chk("cause pulse", pulses, 1);
    chk("irq in rst", undervoltageIrq, 1'b0);
    rd(`LVD_ADDR_CTRL); chk("own rst keep", rd8, 8'h93);
    // any other reset clears control and level, leaves mask
    wr(`LVD_ADDR_LEVEL, 8'h05, 8'hFF);
    @(posedge clk) otherRstReq <= 1'b1;
    @(posedge clk) otherRstReq <= 1'b0;
    cmpOutAsync <= 1'b0;
    rd(`LVD_ADDR_CTRL); chk("other rst", rd8, 8'h00);
    rd(`LVD_ADDR_LEVEL); chk("other lvl", rd8, 8'h00);
    rd(`LVD_ADDR_IRQ); chk("mask kept", rd8, 8'h02);
    cyc(4);
    chk("reset drop", lvdResetReq, 1'b0);
    // stop sequences: byte write of zero, then ordered bit writes
    wr(`LVD_ADDR_CTRL, 8'h90, 8'hFF);
    wr(`LVD_ADDR_CTRL, 8'h00, 8'hFF);
    #1 chk("stop byte", {cmpEnable, refEnable}, 2'b00);
    wr(`LVD_ADDR_CTRL, 8'h92, 8'hFF);
    wr(`LVD_ADDR_CTRL, 8'h00, 8'h02);
    wr(`LVD_ADDR_CTRL, 8'h00, 8'h80);
    #1 chk("stop cmp", {cmpEnable, refEnable}, 2'b01);
    wr(`LVD_ADDR_CTRL, 8'h00, 8'h10);
    #1 chk("stop ref", {cmpEnable, refEnable, lvdResetReq}, 3'b000);
    // unmask, so that only the pin reset can set the mask again
    wr(`LVD_ADDR_IRQ, 8'h00, 8'hFF);
    $display("test reset mode done");
    // pin reset in mid-run masks the interrupt again
    @(posedge clk) rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    rd(`LVD_ADDR_IRQ); chk("mask pin", rd8, 8'h02);
    $display("test pin reset done");
    give_verdict();
  end
endmodule // lvd_control_bench

/* lvd_pkg.sv */
// types shared by the low-voltage detector control block
package lvd_pkg;
  // one register-port request, all strobes and fields together
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic wr;
    logic rd;
  } lvd_bus_t;
  // software-owned control bits that survive the detector's own reset
  typedef struct packed {
    logic cmpEn;
    logic refEn;
    logic actSel;
  } lvd_ctrl_t;
endpackage
